/* File: rtl/timer_ch3.sv */
`timescale 1ns/100ps
module timer_ch3 (
    input  wire logic               mclk,
    input  wire logic               rst_b,
    input  wire timer_pkg::ctrl_s   ctrl,
    input  wire logic               ch3_capture_input,
    input  wire logic               pb_req,
    input  wire logic               pb_we,
    input  wire logic [31:0]        pb_addr,
    input  wire logic [15:0]        pb_wdata,
    output logic                    pb_ack,
    output logic [15:0]             pb_rdata,
    output timer_pkg::irq_s         irq,
    output logic                    counter_overflow_flag,
    output logic                    ch0_timer_output,
    output logic                    ch3_timer_output,
    output logic [15:0]             sixteen_bit_timer_q
);
    timer_pkg::state_s s_r;
    timer_pkg::state_s s_nxt;
    logic              cap_edge;
    logic              capture_use;
    logic              compare_use;
    logic              ch0_clear;
    logic              hit;
    logic [15:0]       cnt_inc;

    // Capture pin crosses into mclk here
    capture_edge u_edge (
        .mclk  (mclk),
        .rst_b (rst_b),
        .pin   (ch3_capture_input),
        .sel   (ctrl.ch3_edge),
        .hit   (cap_edge)
    );

    // Channel 3 role decode
    always_comb begin
        capture_use = 1'b0;
        compare_use = 1'b1;
        if (ctrl.mode == timer_pkg::MODE_FREE_RUN) begin
            capture_use = ctrl.ch3_function_select;
            compare_use = ~ctrl.ch3_function_select;
        end else if (ctrl.mode == timer_pkg::MODE_PULSE_WIDTH) begin
            capture_use = 1'b1;
            compare_use = 1'b0;
        end
    end

    assign cnt_inc   = s_r.cnt + timer_pkg::CNT_STEP;
    assign ch0_clear = (ctrl.mode == timer_pkg::MODE_INTERVAL)
                     & (s_r.cnt == ctrl.ch0_capture_compare);
    assign hit       = (pb_addr == timer_pkg::CCR3_ADDR);

    // Next state: counter, capture, compare and the register port
    always_comb begin
        s_nxt     = s_r;
        s_nxt.irq = '0;
        s_nxt.ack = 1'b0;

        // Counter; held at zero while stopped
        if (!ctrl.counter_run_enable) begin
            s_nxt.cnt = timer_pkg::CNT_ZERO;
        end else if (capture_use && cap_edge &&
                     ctrl.mode == timer_pkg::MODE_PULSE_WIDTH) begin
            s_nxt.cnt = timer_pkg::CNT_ZERO;
        end else if (ch0_clear) begin
            // Clearing on match, even at all ones, is not an overflow
            s_nxt.cnt = timer_pkg::CNT_ZERO;
            s_nxt.irq.ch0_match_irq = 1'b1;
            if (ctrl.ch0_out_enable) begin
                s_nxt.ch0_timer_output = ~s_r.ch0_timer_output;
            end
        end else begin
            s_nxt.cnt = cnt_inc;
            if (s_r.cnt == timer_pkg::CNT_ONES) begin
                s_nxt.irq.counter_overflow_irq = 1'b1;
            end
        end

        // Overflow flag: a wrap in the clear cycle still sets it
        if (ctrl.overflow_clear) begin
            s_nxt.counter_overflow_flag = 1'b0;
        end
        if (s_nxt.irq.counter_overflow_irq) begin
            s_nxt.counter_overflow_flag = 1'b1;
        end

        // Compare against the buffer as each new count is reached
        if (ctrl.counter_run_enable && compare_use &&
            s_r.cnt != s_nxt.cnt && s_nxt.cnt == s_r.ch3_buffer) begin
            s_nxt.irq.ch3_match_irq = 1'b1;
            if (ctrl.ch3_out_enable) begin
                s_nxt.ch3_timer_output = ~s_r.ch3_timer_output;
            end
        end

        // Capture stores the pre-clear count
        if (ctrl.counter_run_enable && capture_use && cap_edge) begin
            s_nxt.ch3_capture_compare = s_r.cnt;
        end

        // Register port: one whole word per request
        case (s_r.bus)
            timer_pkg::BUS_IDLE: begin
                if (pb_req && ctrl.clk_prohibited) begin
                    s_nxt.bus = timer_pkg::BUS_STUCK;
                end else if (pb_req) begin
                    s_nxt.bus   = timer_pkg::BUS_ACK;
                    s_nxt.ack   = 1'b1;
                    s_nxt.rdata = timer_pkg::CNT_ZERO;
                    if (hit && !pb_we) begin
                        // Old word from the flop, never half a capture
                        s_nxt.rdata = s_r.ch3_capture_compare;
                    end else if (hit && compare_use) begin
                        s_nxt.ch3_capture_compare = pb_wdata;
                        s_nxt.ch3_buffer          = pb_wdata;
                    end else if (hit && !cap_edge) begin
                        // Capture wins over a write in the same cycle
                        s_nxt.ch3_capture_compare = pb_wdata;
                    end
                end
            end
            timer_pkg::BUS_ACK: begin
                s_nxt.bus = timer_pkg::BUS_IDLE;
            end
            timer_pkg::BUS_STUCK: begin
                s_nxt.bus = timer_pkg::BUS_STUCK;
            end
            default: begin
                s_nxt.bus = timer_pkg::BUS_IDLE;
            end
        endcase
    end

    // Whole state is one register; reset clears the channel word
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r                     <= '0;
            s_r.ch3_capture_compare <= timer_pkg::CCR3_RESET;
            s_r.ch3_buffer          <= timer_pkg::CCR3_RESET;
            s_r.bus                 <= timer_pkg::BUS_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pb_ack                = s_r.ack;
    assign pb_rdata              = s_r.rdata;
    assign irq                   = s_r.irq;
    assign counter_overflow_flag = s_r.counter_overflow_flag;
    assign ch0_timer_output      = s_r.ch0_timer_output;
    assign ch3_timer_output      = s_r.ch3_timer_output;
    assign sixteen_bit_timer_q   = s_r.cnt;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    cap_role_a: assert property (
        (ctrl.mode == timer_pkg::MODE_FREE_RUN)
        |-> (capture_use == ctrl.ch3_function_select))
        else $error("free-run channel role not from select bit");

    pw_capture_a: assert property (
        (ctrl.mode == timer_pkg::MODE_PULSE_WIDTH)
        |-> (capture_use && !compare_use))
        else $error("pulse width mode not capture only");

    other_compare_a: assert property (
        (ctrl.mode != timer_pkg::MODE_FREE_RUN &&
         ctrl.mode != timer_pkg::MODE_PULSE_WIDTH)
        |-> (compare_use && !capture_use))
        else $error("other mode not compare only");

    write_lands_a: assert property (
        (s_r.bus == timer_pkg::BUS_IDLE && pb_req && pb_we && hit &&
         !ctrl.clk_prohibited && compare_use)
        |=> (s_r.ch3_buffer == $past(pb_wdata) && pb_ack))
        else $error("compare write not in buffer");

    match_irq_a: assert property (
        (ctrl.counter_run_enable && compare_use &&
         s_nxt.cnt != s_r.cnt && s_nxt.cnt == s_r.ch3_buffer)
        |=> irq.ch3_match_irq)
        else $error("channel 3 match request missing");

    out_toggle_a: assert property (
        (irq.ch3_match_irq && $past(ctrl.ch3_out_enable))
        |-> (ch3_timer_output != $past(ch3_timer_output)))
        else $error("channel 3 output did not invert");

    capture_store_a: assert property (
        (ctrl.counter_run_enable && capture_use && cap_edge)
        |=> (s_r.ch3_capture_compare == $past(s_r.cnt)))
        else $error("capture did not store count");

    pw_clear_a: assert property (
        (ctrl.counter_run_enable && cap_edge &&
         ctrl.mode == timer_pkg::MODE_PULSE_WIDTH)
        |=> (sixteen_bit_timer_q == timer_pkg::CNT_ZERO))
        else $error("pulse width edge did not clear counter");

    ones_wrap_a: assert property (
        (ctrl.counter_run_enable && ch0_clear &&
         sixteen_bit_timer_q == timer_pkg::CNT_ONES)
        |=> (irq.ch0_match_irq && !irq.counter_overflow_irq &&
             sixteen_bit_timer_q == timer_pkg::CNT_ZERO))
        else $error("all-ones compare wrap misbehaved");

    stuck_bus_a: assert property (
        (s_r.bus == timer_pkg::BUS_STUCK) |=> (!pb_ack)[*4])
        else $error("stalled access was answered");

    cov_capture_c: cover property (capture_use && cap_edge);
    cov_match_c: cover property (irq.ch3_match_irq);
    cov_wrap_c: cover property (irq.ch0_match_irq &&
                                $past(sixteen_bit_timer_q) ==
                                timer_pkg::CNT_ONES);
    cov_read_c: cover property (pb_ack && !pb_we);

endmodule : timer_ch3

/* File: rtl/timer_pkg.sv */
//Behaviour
// - In free-running mode channel 3 is capture or compare as its function select bit says.
// - In pulse width measurement mode channel 3 works only as a capture register.
// - In every other mode channel 3 works only as a compare register.
// - Channel 3 is read and written as whole 16-bit words, also while the timer runs.
// - Reset clears the channel 3 register to zero.
// - An access made under a prohibited clock condition stalls the bus until reset.
// - In compare use a write is accepted while running and goes to the buffer register.
// - Counter equal to the channel 3 buffer raises the channel 3 match request.
// - On a channel 3 match with its output enabled the output pin inverts.
// - Free-running capture stores the counter on each valid capture edge.
// - Pulse width capture stores the counter and clears the counter to zero.
// - A read that meets a capture still returns one consistent register value.
// - In interval mode with channel 0 at all ones, channel 0 matches and toggles in the same cycle that the counter wraps to zero.
// - That all-ones wrap neither raises the overflow request nor sets its flag.
package timer_pkg;

    localparam logic [31:0] CCR3_ADDR  = 32'hFFFFF54C;
    localparam logic [15:0] CCR3_RESET = 16'h0000;
    localparam logic [15:0] CNT_ZERO   = 16'h0000;
    localparam logic [15:0] CNT_ONES   = 16'hFFFF;
    localparam logic [15:0] CNT_STEP   = 16'h0001;

    typedef enum logic [2:0] {
        MODE_INTERVAL,
        MODE_EXT_EVENT,
        MODE_EXT_TRIG,
        MODE_ONE_SHOT,
        MODE_PWM,
        MODE_FREE_RUN,
        MODE_PULSE_WIDTH,
        MODE_SPARE
    } mode_e;

    typedef enum logic [1:0] {
        EDGE_NONE,
        EDGE_RISE,
        EDGE_FALL,
        EDGE_BOTH
    } edge_e;

    typedef enum {
        BUS_IDLE,
        BUS_ACK,
        BUS_STUCK
    } bus_e;

    // Loose control bits held by neighbouring timer registers
    typedef struct packed {
        logic        counter_run_enable;
        mode_e       mode;
        logic        ch3_function_select;
        logic        ch3_out_enable;
        logic        ch0_out_enable;
        edge_e       ch3_edge;
        logic        overflow_clear;
        logic [15:0] ch0_capture_compare;
        logic        clk_prohibited;
    } ctrl_s;

    typedef struct packed {
        logic ch0_match_irq;
        logic ch3_match_irq;
        logic counter_overflow_irq;
    } irq_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] ch3_capture_compare;
        logic [15:0] ch3_buffer;
        logic        counter_overflow_flag;
        irq_s        irq;
        logic        ch0_timer_output;
        logic        ch3_timer_output;
        bus_e        bus;
        logic        ack;
        logic [15:0] rdata;
    } state_s;

    typedef struct packed {
        logic  meta;
        logic  sync;
        logic  prev;
        logic  hit;
    } edge_state_s;

endpackage : timer_pkg

/* File: rtl/capture_edge.sv */
`timescale 1ns/100ps
// Synchronises the capture pin and flags the selected edge for one cycle
module capture_edge (
    input  wire logic            mclk,
    input  wire logic            rst_b,
    input  wire logic            pin,
    input  wire timer_pkg::edge_e sel,
    output logic                 hit
);
    timer_pkg::edge_state_s s_r;
    timer_pkg::edge_state_s s_nxt;

    // Only the second and third stages feed the edge compare
    always_comb begin
        s_nxt      = s_r;
        s_nxt.meta = pin;
        s_nxt.sync = s_r.meta;
        s_nxt.prev = s_r.sync;
        case (sel)
            timer_pkg::EDGE_RISE: s_nxt.hit = s_r.sync & ~s_r.prev;
            timer_pkg::EDGE_FALL: s_nxt.hit = ~s_r.sync & s_r.prev;
            timer_pkg::EDGE_BOTH: s_nxt.hit = s_r.sync ^ s_r.prev;
            default:              s_nxt.hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hit = s_r.hit;

endmodule : capture_edge

/* File: dv/capture_pin_model.sv */
`timescale 1ns/100ps
// Capture pin source: the pin holds its level between commanded changes
module capture_pin_model (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic flip,
    output logic      pin
);
    // Level changes only off the sampling edge, so sync timing stays exact
    always @(negedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pin <= 1'b0;
        end else if (flip) begin
            pin <= ~pin;
        end
    end
endmodule : capture_pin_model

/* File: dv/timer_ch3_capture_compare_tb.sv */
`timescale 1ns/100ps
module timer_ch3_capture_compare_tb;
    logic                mclk, rst_b, pb_req, pb_we, pb_ack, pin, flip;
    logic [31:0]         pb_addr;
    logic [15:0]         pb_wdata, pb_rdata, q, rd;
    timer_pkg::ctrl_s    ctrl;
    timer_pkg::irq_s     irq;
    logic                ovf, out0, out3, ov_seen;
    int                  fails, total_checks;

    timer_ch3 DUT (.mclk(mclk), .rst_b(rst_b), .ctrl(ctrl),
        .ch3_capture_input(pin), .pb_req(pb_req), .pb_we(pb_we),
        .pb_addr(pb_addr), .pb_wdata(pb_wdata), .pb_ack(pb_ack),
        .pb_rdata(pb_rdata), .irq(irq), .counter_overflow_flag(ovf),
        .ch0_timer_output(out0), .ch3_timer_output(out3),
        .sixteen_bit_timer_q(q));
    capture_pin_model pin_src (.mclk(mclk), .rst_b(rst_b), .flip(flip),
        .pin(pin));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Records any overflow pulse while a test watches for one
    always @(posedge mclk) begin
        if (irq.counter_overflow_irq === 1'b1) ov_seen <= 1'b1;
    end

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude

    task automatic do_reset;
        rst_b = 1'b0;
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
    endtask : do_reset

    // One bus access; request held until the ack is seen or 20 cycles pass, then dropped
    task automatic access(logic we, logic [31:0] a, logic [15:0] d,
                          output logic acked);
        int n;
        @(negedge mclk);
        pb_req = 1'b1;
        pb_we = we;
        pb_addr = a;
        pb_wdata = d;
        acked = 1'b0;
        for (n = 0; n < 20 && !acked; n++) begin
            @(negedge mclk);
            acked = (pb_ack === 1'b1);
        end
        rd = pb_rdata;
        pb_req = 1'b0;
    endtask : access

    task automatic wr(logic [15:0] d);
        logic ok;
        access(1'b1, timer_pkg::CCR3_ADDR, d, ok);
        check("write ack", {15'h0, ok}, 16'h0001);
    endtask : wr

    task automatic rd_check(string name, logic [15:0] exp);
        logic ok;
        access(1'b0, timer_pkg::CCR3_ADDR, 16'h0000, ok);
        check(name, rd, exp);
    endtask : rd_check

    // Restart the counter from zero in the given mode
    task automatic start(timer_pkg::mode_e m, logic fs,
                         timer_pkg::edge_e e);
        @(negedge mclk);
        ctrl.counter_run_enable = 1'b0;
        ctrl.mode = m;
        ctrl.ch3_function_select = fs;
        ctrl.ch3_edge = e;
        @(negedge mclk);
        ctrl.counter_run_enable = 1'b1;
    endtask : start

    task automatic wait_ch3(logic [15:0] v);
        int n;
        for (n = 0; n < 400 && irq.ch3_match_irq !== 1'b1; n++)
            @(negedge mclk);
        check("ch3 match count", q, v);
    endtask : wait_ch3

    task automatic test_reset;
        logic ok;
        rd_check("reset value", 16'h0000);
        access(1'b0, 32'hFFFFF540, 16'h0000, ok);
        check("unmapped read", rd, 16'h0000);
        $display("test reset done");
    endtask : test_reset

    task automatic test_compare;
        logic o;
        start(timer_pkg::MODE_FREE_RUN, 1'b0, timer_pkg::EDGE_NONE);
        ctrl.ch3_out_enable = 1'b1;
        o = out3;
        wr(16'h0040);
        wait_ch3(16'h0040);
        check("ch3 toggle", {15'h0, out3}, {15'h0, ~o});
        wr(16'h0080);
        wait_ch3(16'h0080);
        rd_check("compare readback", 16'h0080);
        start(timer_pkg::MODE_ONE_SHOT, 1'b1, timer_pkg::EDGE_NONE);
        wr(16'h0020);
        wait_ch3(16'h0020);
        $display("test compare done");
    endtask : test_compare

    // Flip request by non-blocking assignment so the pin model never races
    // it; the pin moves one falling edge later and the capture lands at 14
    task automatic capture(timer_pkg::mode_e m, logic fs,
                           timer_pkg::edge_e e);
        start(m, fs, e);
        repeat (10) @(negedge mclk);
        flip <= 1'b1;
        @(negedge mclk);
        flip <= 1'b0;
    endtask : capture

    task automatic test_capture;
        capture(timer_pkg::MODE_FREE_RUN, 1'b1, timer_pkg::EDGE_RISE);
        repeat (6) @(negedge mclk);
        rd_check("free run capture", 16'h000E);
        capture(timer_pkg::MODE_PULSE_WIDTH, 1'b0, timer_pkg::EDGE_FALL);
        repeat (4) @(negedge mclk);
        check("pulse width clear", q, 16'h0000);
        rd_check("pulse width capture", 16'h000E);
        capture(timer_pkg::MODE_FREE_RUN, 1'b1, timer_pkg::EDGE_NONE);
        // A marker word that a false capture would overwrite
        wr(16'h0123);
        repeat (6) @(negedge mclk);
        rd_check("no edge no capture", 16'h0123);
        capture(timer_pkg::MODE_FREE_RUN, 1'b1, timer_pkg::EDGE_BOTH);
        // Read taken on the very edge that stores the capture
        repeat (2) @(negedge mclk);
        rd_check("read meets capture", 16'h0123);
        rd_check("both edges capture", 16'h000E);
        $display("test capture done");
    endtask : test_capture

    task automatic test_all_ones;
        int n;
        logic o;
        ctrl.ch0_capture_compare = 16'hFFFF;
        ctrl.ch0_out_enable = 1'b1;
        start(timer_pkg::MODE_INTERVAL, 1'b0, timer_pkg::EDGE_NONE);
        ov_seen = 1'b0;
        o = out0;
        for (n = 0; n < 70000 && irq.ch0_match_irq !== 1'b1; n++)
            @(negedge mclk);
        check("wrap to zero", q, 16'h0000);
        check("ch0 toggle", {15'h0, out0}, {15'h0, ~o});
        check("no overflow irq", {15'h0, ov_seen}, 16'h0000);
        check("no overflow flag", {15'h0, ovf}, 16'h0000);
        $display("test all ones done");
    endtask : test_all_ones

    task automatic test_stall;
        logic ok;
        ctrl.clk_prohibited = 1'b1;
        access(1'b0, timer_pkg::CCR3_ADDR, 16'h0000, ok);
        check("stalled access", {15'h0, ok}, 16'h0000);
        ctrl.clk_prohibited = 1'b0;
        repeat (5) @(negedge mclk);
        check("still stalled", {15'h0, pb_ack}, 16'h0000);
        do_reset();
        rd_check("after reset", 16'h0000);
        $display("test stall done");
    endtask : test_stall

    initial begin
        fails = 0;
        total_checks = 0;
        ctrl = '0;
        pb_req = 1'b0;
        pb_we = 1'b0;
        pb_addr = 32'h00000000;
        pb_wdata = 16'h0000;
        flip = 1'b0;
        ov_seen = 1'b0;
        do_reset();
        test_reset();
        test_compare();
        test_capture();
        test_all_ones();
        test_stall();
        conclude();
    end

    // Watchdog sized above the long all-ones wrap test
    initial begin
        repeat (90000) @(posedge mclk);
        fails++;
        conclude();
    end
endmodule : timer_ch3_capture_compare_tb
